/* File: mpurc_pkg.sv */
// Purpose: shared constants for the region configuration registers
// Assumes: one build-time choice of mask or limit variant
// Notes: field positions are register bit numbers

package mpurc_pkg;

    // ----------------------------------------------------------------
    // build options
    // ----------------------------------------------------------------
    localparam bit USE_LIMIT = 1'b0;
    localparam int NUM_DATA_REGIONS = 8;
    localparam int NUM_INST_REGIONS = 8;
    localparam int MIN_DATA_LOG2 = 12;
    localparam int MIN_INST_LOG2 = 12;

    // ----------------------------------------------------------------
    // selector layout
    // ----------------------------------------------------------------
    localparam int SEL_D_BIT = 0;
    localparam int SEL_IDX_LSB = 1;
    localparam int SEL_IDX_W = 5;
    localparam int FIELD_MSB = 30;
    localparam int LOW_KEEP_W = 6;
    localparam logic [31:0] SEL_WR_MASK = 32'h7FFFFFFF;

    // ----------------------------------------------------------------
    // attribute layout
    // ----------------------------------------------------------------
    localparam int ATTR_WR_BIT = 0;
    localparam int ATTR_RD_BIT = 1;
    localparam int ATTR_PERMISSION_CODE_LSB = 2;
    localparam int ATTR_PERMISSION_CODE_W = 3;
    localparam int ATTR_C_BIT = 5;
    localparam int ATTR_TOP_BIT = 31;
    localparam logic [31:0] ATTR_TRIG_CLR = 32'hFFFFFFFC;

    // ----------------------------------------------------------------
    // reset values and mask reference
    // ----------------------------------------------------------------
    localparam logic [31:0] REG_RESET = 32'h00000000;
    localparam logic [24:0] MASK_ONES = 25'h1FFFFFF;
    localparam int MASK_SHIFT = 6;

    // ----------------------------------------------------------------
    // register select on the control port
    // ----------------------------------------------------------------
    localparam logic SEL_SELECTOR = 1'b0;
    localparam logic SEL_ATTRIBUTES = 1'b1;

    // ----------------------------------------------------------------
    // permission codes
    // ----------------------------------------------------------------
    localparam logic [2:0] PERMISSION_CODE_NONE = 3'h0;
    localparam logic [2:0] PERMISSION_CODE_SUP_R = 3'h1;
    localparam logic [2:0] PERMISSION_CODE_ALL_R = 3'h2;
    localparam logic [2:0] PERMISSION_CODE_SUP_RW = 3'h4;
    localparam logic [2:0] PERMISSION_CODE_SUP_RW_USR_R = 3'h5;
    localparam logic [2:0] PERMISSION_CODE_ALL_RW = 3'h6;

    function automatic logic mpurc_permission_code_ok(
        input logic is_data,
        input logic is_write,
        input logic is_user,
        input logic [2:0] code
    );
        logic ok;
        ok = 1'b0;
        if (!is_data) begin
            ok = (code == PERMISSION_CODE_ALL_R) || ((code == PERMISSION_CODE_SUP_R) && !is_user);
        end else begin
            unique case (code)
                PERMISSION_CODE_SUP_R: ok = !is_user && !is_write;
                PERMISSION_CODE_ALL_R: ok = !is_write;
                PERMISSION_CODE_SUP_RW: ok = !is_user;
                PERMISSION_CODE_SUP_RW_USR_R: ok = !is_user || !is_write;
                PERMISSION_CODE_ALL_RW: ok = 1'b1;
                default: ok = 1'b0;
            endcase
        end
        return ok;
    endfunction : mpurc_permission_code_ok

endpackage : mpurc_pkg

/* File: mpurc_tbl_if.sv */
// Purpose: link between the register front end and one region table
// Assumes: words carry register-format images
// Notes: index is the raw selector index field

interface mpurc_tbl_if;
    logic wr_en;
    logic [4:0] idx;
    logic [31:0] wr_sel_word;
    logic [31:0] wr_attr_word;
    logic [31:0] rd_sel_word;
    logic [31:0] rd_attr_word;
    logic [30:0] look_addr;
    logic look_hit;
    logic [2:0] look_permission_code;
    logic look_c;

    modport ctl (
        output wr_en, idx, wr_sel_word, wr_attr_word, look_addr,
        input rd_sel_word, rd_attr_word, look_hit, look_permission_code, look_c
    );
    modport tbl (
        input wr_en, idx, wr_sel_word, wr_attr_word, look_addr,
        output rd_sel_word, rd_attr_word, look_hit, look_permission_code, look_c
    );
endinterface : mpurc_tbl_if

/* File: mpurc_table.sv */
// Purpose: region record store and priority address match for one type
// Assumes: rst_n already synchronised
// Notes: out-of-range index writes are dropped, reads give zero

module mpurc_table import mpurc_pkg::*; #(
    parameter int NUM_REGIONS = 8,
    parameter int MIN_LOG2 = 12
) (
    input wire logic clk,
    input wire logic rst_n,
    mpurc_tbl_if.tbl tb
);
    localparam int IW = $clog2(NUM_REGIONS);
    localparam int BW = FIELD_MSB + 1 - MIN_LOG2;

    logic [BW-1:0] base_r [NUM_REGIONS];
    logic [BW-1:0] base_nxt [NUM_REGIONS];
    logic [BW:0] size_r [NUM_REGIONS];
    logic [BW:0] size_nxt [NUM_REGIONS];
    logic [2:0] permission_code_r [NUM_REGIONS];
    logic [2:0] permission_code_nxt [NUM_REGIONS];
    logic [NUM_REGIONS-1:0] c_r;
    logic [NUM_REGIONS-1:0] c_nxt;
    logic idx_ok;
    logic [IW-1:0] k;
    logic [BW-1:0] a;

    assign idx_ok = tb.idx < 5'(NUM_REGIONS);
    assign k = tb.idx[IW-1:0];
    assign a = tb.look_addr[FIELD_MSB:MIN_LOG2];

    // ----------------------------------------------------------------
    // record store
    // ----------------------------------------------------------------
    always_comb begin
        base_nxt = base_r;
        size_nxt = size_r;
        permission_code_nxt = permission_code_r;
        c_nxt = c_r;
        if (tb.wr_en && idx_ok) begin
            base_nxt[k] = tb.wr_sel_word[FIELD_MSB:MIN_LOG2];
            if (USE_LIMIT) begin
                size_nxt[k] = tb.wr_attr_word[ATTR_TOP_BIT:MIN_LOG2];
            end else begin
                size_nxt[k] = {1'b0, tb.wr_attr_word[FIELD_MSB:MIN_LOG2]};
            end
            permission_code_nxt[k] = tb.wr_attr_word[ATTR_PERMISSION_CODE_LSB +: ATTR_PERMISSION_CODE_W];
            c_nxt[k] = tb.wr_attr_word[ATTR_C_BIT];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_REGIONS; i++) begin
                base_r[i] <= '0;
                size_r[i] <= '0;
                permission_code_r[i] <= '0;
            end
            c_r <= '0;
        end else begin
            base_r <= base_nxt;
            size_r <= size_nxt;
            permission_code_r <= permission_code_nxt;
            c_r <= c_nxt;
        end
    end

    // ----------------------------------------------------------------
    // read-back images
    // ----------------------------------------------------------------
    always_comb begin
        tb.rd_sel_word = REG_RESET;
        tb.rd_attr_word = REG_RESET;
        if (idx_ok) begin
            tb.rd_sel_word = {1'b0, base_r[k], {MIN_LOG2{1'b0}}};
            tb.rd_attr_word = {size_r[k], {MIN_LOG2{1'b0}}};
            if (!USE_LIMIT) begin
                tb.rd_attr_word[ATTR_TOP_BIT] = 1'b0;
            end
            tb.rd_attr_word[ATTR_PERMISSION_CODE_LSB +: ATTR_PERMISSION_CODE_W] = permission_code_r[k];
            tb.rd_attr_word[ATTR_C_BIT] = c_r[k];
        end
    end

    // ----------------------------------------------------------------
    // priority match: walk downward so the lowest index wins
    // ----------------------------------------------------------------
    always_comb begin
        tb.look_hit = 1'b0;
        tb.look_permission_code = PERMISSION_CODE_NONE;
        tb.look_c = 1'b0;
        for (int i = NUM_REGIONS - 1; i >= 0; i--) begin
            if (USE_LIMIT ? ({1'b0, a} >= {1'b0, base_r[i]} && {1'b0, a} < size_r[i])
                          : ((a & size_r[i][BW-1:0]) == base_r[i])) begin
                tb.look_hit = 1'b1;
                tb.look_permission_code = permission_code_r[i];
                tb.look_c = c_r[i];
            end
        end
    end

endmodule : mpurc_table

/* File: mpurc_regs.sv */
// Purpose: region selector and attribute registers of a protection unit
// Assumes: control port driven by core logic on clk
// Notes: region tables live in mpurc_table, one per region type
//
// Functional notes
// - selector base field, read-write, resets zero
// - type bit one data, zero instruction
// - base is start address over minimum size
// - lower index means higher region priority
// - build option picks mask or limit field
// - mask variant: bit31 zero, fixed low fields
// - limit variant: limit from bit31, same low
// - cacheable flag meaningful for data regions only
// - read trigger loads record into registers
// - write trigger stores registers as record
// - mask is ones shifted by size log
// - mask encodings span 4 KB to 2GB
// - limit is exclusive end in size units
// - instruction permission codes for execute
// - data permission codes for read and write
// - region counts are build parameters, 2..32; the code works for 2..31, as at 32 its 5-bit index bound wraps to zero

module mpurc_regs import mpurc_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ctl_wr_en,
    input wire logic ctl_wr_sel,
    input wire logic [31:0] ctl_wr_data,
    input wire logic ctl_rd_sel,
    output logic [31:0] ctl_rd_data_r,
    input wire logic chk_valid,
    input wire logic [31:0] chk_addr,
    input wire logic chk_is_data,
    input wire logic chk_is_write,
    input wire logic chk_user,
    output logic chk_done_r,
    output logic chk_fault_r,
    output logic chk_cacheable_r
);

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    logic rst_meta_r;
    logic rst_sync_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    // ----------------------------------------------------------------
    // region tables
    // ----------------------------------------------------------------
    mpurc_tbl_if dtbl ();
    mpurc_tbl_if itbl ();

    mpurc_table #(
        .NUM_REGIONS(NUM_DATA_REGIONS),
        .MIN_LOG2(MIN_DATA_LOG2)
    ) u_dtbl (
        .clk(clk),
        .rst_n(rst_sync_r),
        .tb(dtbl.tbl)
    );

    mpurc_table #(
        .NUM_REGIONS(NUM_INST_REGIONS),
        .MIN_LOG2(MIN_INST_LOG2)
    ) u_itbl (
        .clk(clk),
        .rst_n(rst_sync_r),
        .tb(itbl.tbl)
    );

    // ----------------------------------------------------------------
    // register state
    // ----------------------------------------------------------------
    logic [31:0] sel_r;
    logic [31:0] sel_nxt;
    logic [31:0] attr_r;
    logic [31:0] attr_nxt;
    logic [31:0] rd_data_nxt;
    logic sel_is_data;
    logic attr_wr;
    logic trig_wr;
    logic trig_rd;
    logic [31:0] attr_wmask;
    logic [31:0] rec_sel_word;
    logic [31:0] rec_attr_word;

    assign sel_is_data = sel_r[SEL_D_BIT];
    assign attr_wr = ctl_wr_en && (ctl_wr_sel == SEL_ATTRIBUTES);
    assign trig_wr = attr_wr && ctl_wr_data[ATTR_WR_BIT];
    // both triggers at once is undefined; the store is taken and the load dropped
    assign trig_rd = attr_wr && ctl_wr_data[ATTR_RD_BIT] && !ctl_wr_data[ATTR_WR_BIT];

    // triggers never stored, so they read zero
    assign attr_wmask = USE_LIMIT ? ATTR_TRIG_CLR : (ATTR_TRIG_CLR & SEL_WR_MASK);

    // type bit picks which table the selector index addresses
    assign rec_sel_word = sel_is_data ? dtbl.rd_sel_word : itbl.rd_sel_word;
    assign rec_attr_word = sel_is_data ? dtbl.rd_attr_word : itbl.rd_attr_word;

    assign dtbl.wr_en = trig_wr && sel_is_data;
    assign itbl.wr_en = trig_wr && !sel_is_data;
    assign dtbl.idx = sel_r[SEL_IDX_LSB +: SEL_IDX_W];
    assign itbl.idx = sel_r[SEL_IDX_LSB +: SEL_IDX_W];
    assign dtbl.wr_sel_word = sel_r;
    assign itbl.wr_sel_word = sel_r;
    // record takes the attribute value carried by the triggering write
    assign dtbl.wr_attr_word = ctl_wr_data & attr_wmask;
    assign itbl.wr_attr_word = ctl_wr_data & attr_wmask;
    assign dtbl.look_addr = chk_addr[30:0];
    assign itbl.look_addr = chk_addr[30:0];

    always_comb begin
        sel_nxt = sel_r;
        attr_nxt = attr_r;
        if (ctl_wr_en && (ctl_wr_sel == SEL_SELECTOR)) begin
            sel_nxt = ctl_wr_data & SEL_WR_MASK;
        end
        if (attr_wr) begin
            attr_nxt = ctl_wr_data & attr_wmask;
            if (trig_rd) begin
                // index and type stay; base and attributes come from the record
                sel_nxt = {rec_sel_word[31:LOW_KEEP_W], sel_r[LOW_KEEP_W-1:0]};
                attr_nxt = rec_attr_word & attr_wmask;
            end
        end
    end

    assign rd_data_nxt = (ctl_rd_sel == SEL_ATTRIBUTES) ? attr_r : sel_r;

    always_ff @(posedge clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            sel_r <= REG_RESET;
            attr_r <= REG_RESET;
            ctl_rd_data_r <= REG_RESET;
        end else begin
            sel_r <= sel_nxt;
            attr_r <= attr_nxt;
            ctl_rd_data_r <= rd_data_nxt;
        end
    end

    // ----------------------------------------------------------------
    // access check
    // ----------------------------------------------------------------
    logic chk_hit;
    logic [2:0] chk_permission_code;
    logic chk_c;
    logic done_nxt;
    logic fault_nxt;
    logic cache_nxt;

    always_comb begin
        chk_hit = chk_is_data ? dtbl.look_hit : itbl.look_hit;
        chk_permission_code = chk_is_data ? dtbl.look_permission_code : itbl.look_permission_code;
        chk_c = chk_is_data ? dtbl.look_c : itbl.look_c;
        done_nxt = chk_valid;
        fault_nxt = 1'b0;
        cache_nxt = 1'b0;
        if (chk_valid) begin
            fault_nxt = !chk_hit || !mpurc_permission_code_ok(chk_is_data, chk_is_write, chk_user, chk_permission_code);
            cache_nxt = chk_is_data && chk_hit && chk_c && !fault_nxt;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            chk_done_r <= 1'b0;
            chk_fault_r <= 1'b0;
            chk_cacheable_r <= 1'b0;
        end else begin
            chk_done_r <= done_nxt;
            chk_fault_r <= fault_nxt;
            chk_cacheable_r <= cache_nxt;
        end
    end

endmodule : mpurc_regs

/* File: mpurc_regs_monitor.sv */
// Purpose: port checker for the region configuration registers
// Assumes: mask variant, 4 KB minimum regions
// Notes: bound to mpurc_regs from the testbench top file
module mpurc_regs_monitor (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ctl_wr_en,
    input wire logic ctl_wr_sel,
    input wire logic [31:0] ctl_wr_data,
    input wire logic ctl_rd_sel,
    input wire logic [31:0] ctl_rd_data_r,
    input wire logic chk_valid,
    input wire logic [31:0] chk_addr,
    input wire logic chk_is_data,
    input wire logic chk_is_write,
    input wire logic chk_user,
    input wire logic chk_done_r,
    input wire logic chk_fault_r,
    input wire logic chk_cacheable_r
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // ----------------------------------------------------------------
    // check path
    // ----------------------------------------------------------------
    done_one_a: assert property (chk_valid |=> chk_done_r)
        else $error("check result missing");
    done_only_a: assert property (!chk_valid |=> !chk_done_r && !chk_fault_r)
        else $error("result without request");
    fault_done_a: assert property (chk_fault_r |-> chk_done_r)
        else $error("fault outside a result");
    cache_ok_a: assert property (chk_cacheable_r |-> chk_done_r && !chk_fault_r && $past(chk_is_data))
        else $error("cacheable on fault or fetch");

    // ----------------------------------------------------------------
    // register path
    // ----------------------------------------------------------------
    trig_zero_a: assert property (ctl_rd_sel |=> ctl_rd_data_r[1:0] == 2'h0)
        else $error("trigger bits read nonzero");
    top_zero_a: assert property (ctl_rd_data_r[31] == 1'b0)
        else $error("bit 31 reads one");
    sel_write_a: assert property ((ctl_wr_en && !ctl_wr_sel) ##1 !ctl_rd_sel
        |=> ctl_rd_data_r[30:0] == $past(ctl_wr_data[30:0], 2))
        else $error("selector readback differs");
    attr_write_a: assert property ((ctl_wr_en && ctl_wr_sel && !ctl_wr_data[1]) ##1 ctl_rd_sel
        |=> ctl_rd_data_r[30:2] == $past(ctl_wr_data[30:2], 2))
        else $error("attribute readback differs");
endmodule : mpurc_regs_monitor

/* File: mpurc_host.sv */
// Purpose: host core model issuing control register writes
// Assumes: caller runs just after a rising edge
// Notes: data lines show a changing pattern once released
module mpurc_host (
    input wire logic clk,
    output logic wr_en,
    output logic wr_sel,
    output logic [31:0] wr_data
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        wr_en = 1'b0;
        wr_sel = 1'b0;
        wr_data = 32'h00000000;
    end

    // unused field bits arrive as zero from the caller
    task automatic put(input logic sel, input logic [31:0] data);
        if (sel && data[1] && data[0]) begin
            data[1] = 1'b0; // both triggers at once is undefined
        end
        @(posedge clk);
        #1;
        wr_en = 1'b1;
        wr_sel = sel;
        wr_data = data;
        @(posedge clk);
        #1;
        wr_en = 1'b0;
        wr_data = ~data;
    endtask : put
endmodule : mpurc_host

/* File: tb.sv */
// Purpose: self-checking bench for mpurc_regs
// Assumes: mask variant, 8 regions per type, 4 KB minimum
// Notes: nested regions at one base expose priority
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin error_cnt++; \
    $display("unexpected %s exp=%h got=%h", nm, exp, got); end end

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ctl_rd_sel = 1'b0;
    logic chk_valid = 1'b0;
    logic chk_is_data = 1'b0;
    logic chk_is_write = 1'b0;
    logic chk_user = 1'b0;
    logic [31:0] chk_addr = 32'h00000000;
    logic ctl_wr_en, ctl_wr_sel, chk_done_r, chk_fault_r, chk_cacheable_r;
    logic [31:0] ctl_wr_data, ctl_rd_data_r;
    logic [31:0] rng = 32'h00000011;
    logic [31:0] m_sel[2][8] = '{default: '0};
    logic [31:0] m_attr[2][8] = '{default: '0};
    int exp_q[$];
    int error_cnt = 0;
    int check_count = 0;

    always #10 clk = ~clk;

    mpurc_host i_host (.clk, .wr_en(ctl_wr_en), .wr_sel(ctl_wr_sel), .wr_data(ctl_wr_data));
    mpurc_regs i_dut (.clk, .rst_n, .ctl_wr_en, .ctl_wr_sel, .ctl_wr_data, .ctl_rd_sel, .ctl_rd_data_r,
        .chk_valid, .chk_addr, .chk_is_data, .chk_is_write, .chk_user, .chk_done_r, .chk_fault_r,
        .chk_cacheable_r);

    // ----------------------------------------------------------------
    // reference model
    // ----------------------------------------------------------------
    function automatic logic [31:0] rnd();
        rng = {rng[30:0], rng[31] ^ rng[21] ^ rng[1] ^ rng[0]};
        return rng;
    endfunction : rnd

    function automatic int allowed(int d, int w, int u, int c);
        if (!d) return c == 2 || (c == 1 && !u);
        case (c)
            1: return !u && !w;
            2: return !w;
            4: return !u;
            5: return !u || !w;
            6: return 1;
            default: return 0;
        endcase
    endfunction : allowed

    // 2 fault, 1 cacheable hit, 0 plain hit; first index wins
    function automatic int expect_chk(int d, int w, int u, logic [31:0] a);
        logic [31:0] b, m;
        for (int i = 0; i < 8; i++) begin
            b = m_sel[d][i];
            m = m_attr[d][i];
            if ((a[30:12] & m[30:12]) == b[30:12] && !(m[30:12] == 0 && b[30:12] != 0)) begin
                if (allowed(d, w, u, m[4:2]) == 0) return 2;
                return d && m[5];
            end
        end
        return 2;
    endfunction : expect_chk

    // ----------------------------------------------------------------
    // register tasks
    // ----------------------------------------------------------------
    task automatic prog_region(int d, int i, logic [31:0] sel, logic [31:0] attr);
        i_host.put(1'b0, sel | (i << 1) | d);
        i_host.put(1'b1, attr | 32'h00000001);
        m_sel[d][i] = sel | (i << 1) | d;
        m_attr[d][i] = attr;
    endtask : prog_region

    task automatic readback(int d, int i);
        i_host.put(1'b0, (i << 1) | d);
        i_host.put(1'b1, 32'h00000002);
        for (int r = 0; r < 2; r++) begin
            ctl_rd_sel = r[0];
            @(posedge clk);
            #1;
            if (r) `CHK("attr", m_attr[d][i], ctl_rd_data_r)
            else `CHK("sel", m_sel[d][i], ctl_rd_data_r)
        end
        ctl_rd_sel = 1'b0;
    endtask : readback

    task automatic stop_test();
        $display("errors %0d checks %0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : stop_test

    initial begin
        repeat (100000) @(posedge clk);
        error_cnt++;
        stop_test();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [31:0] v, attr;
        int e;
        repeat (12) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        `CHK("sel reset", 32'h00000000, ctl_rd_data_r)
        ctl_rd_sel = 1'b1;
        @(posedge clk);
        #1;
        `CHK("attr reset", 32'h00000000, ctl_rd_data_r)
        ctl_rd_sel = 1'b0;
        // plain attribute write, no trigger; unused mask bits kept zero
        v = rnd() & 32'h7FFFF03C;
        i_host.put(1'b1, v);
        ctl_rd_sel = 1'b1;
        @(posedge clk);
        #1;
        `CHK("attr write", v, ctl_rd_data_r)
        ctl_rd_sel = 1'b0;
        for (int r = 0; r < 3; r++) begin
            // smaller regions nest inside larger ones, index 7 spans 2 GB
            for (int d = 0; d < 2; d++) begin
                for (int i = 0; i < 8; i++) begin
                    v = rnd();
                    attr = (i == 7) ? 32'h0 : (32'h7FFFFFFF << (12 + i)) & 32'h7FFFFFFF;
                    if (r == 2 && i == 0) attr = 32'h0; // nonzero base, zero mask: region off
                    attr = attr | (v[5] << 5) | (((i + r) % 8) << 2);
                    prog_region(d, i, (i == 7) ? 32'h0 : 32'h00040000, attr);
                end
            end
            if (r == 0) begin
                for (int k = 0; k < 16; k++) readback(k / 8, k % 8);
            end
            for (int k = 0; k <= 40; k++) begin
                @(posedge clk);
                #1;
                if (k > 0) begin
                    e = exp_q.pop_front();
                    `CHK("done", 1'b1, chk_done_r)
                    `CHK("fault", e == 2, chk_fault_r)
                    `CHK("cacheable", e == 1, chk_cacheable_r)
                end
                v = rnd();
                chk_valid = (k < 40);
                chk_is_data = v[0];
                chk_is_write = v[1];
                chk_user = v[2];
                chk_addr = v[3] ? (32'h00040000 ^ (v & 32'h0007FFFF)) : v;
                if (k < 40) exp_q.push_back(expect_chk(v[0], v[1], v[2], chk_addr));
            end
            @(posedge clk);
            #1;
            `CHK("idle", 1'b0, chk_done_r)
        end
        stop_test();
    end
endmodule : tb

bind mpurc_regs mpurc_regs_monitor i_mon (.clk, .rst_n, .ctl_wr_en, .ctl_wr_sel, .ctl_wr_data, .ctl_rd_sel,
    .ctl_rd_data_r, .chk_valid, .chk_addr, .chk_is_data, .chk_is_write, .chk_user, .chk_done_r,
    .chk_fault_r, .chk_cacheable_r);
